// >>> hdl/stp_pkg.sv
package stp_pkg;
	localparam int STP_DEPTH = 16;
	localparam int STP_AW = 4;
	localparam int STP_CW = 5;
	localparam int STP_TW = 16;
	localparam int STP_CLK_KHZ = 200000;
	localparam int STP_MS_CYCLES = STP_CLK_KHZ;
	localparam logic [17:0] STP_MS_LAST = 18'(STP_MS_CYCLES - 1);
	localparam logic [7:0] STP_BYTE_RST = 8'h00;
	typedef enum logic [1:0] {STP_DTR_NEVER, STP_DTR_REMOTE_DSR_FOLLOW, STP_DTR_CONNECTED, STP_DTR_ALWAYS} stp_dtr_e;
	typedef enum logic [1:0] {STP_PACK_DISABLE, STP_PACK_TIMEOUT, STP_PACK_SENDCHAR} stp_pack_e;
endpackage

// >>> hdl/stp_packer.sv
`timescale 1ns/10ps
module stp_packer
	import stp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire stp_pkg::stp_dtr_e dtr_policy,
	input wire stp_pkg::stp_pack_e pack_mode,
	input wire logic [stp_pkg::STP_CW-1:0] buf_size,
	input wire logic [stp_pkg::STP_CW-1:0] threshold,
	input wire logic [stp_pkg::STP_TW-1:0] timeout_ms,
	input wire logic [7:0] send_char,
	input wire logic trail_en,
	input wire logic [7:0] trail_char,
	input wire logic accept_active,
	input wire logic connect_active,
	input wire logic remote_dsr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic tx_ready,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic dtr,
	output logic [stp_pkg::STP_CW-1:0] queued
);
	import stp_pkg::*;

	typedef enum logic [1:0] {STP_FILL, STP_SEND, STP_TRAIL} stp_state_e;
	typedef struct packed {
		stp_state_e st;
		logic [STP_DEPTH-1:0][7:0] mem;
		logic [STP_AW-1:0] rd;
		logic [STP_AW-1:0] wr;
		logic [STP_CW-1:0] cnt;
		logic [STP_CW-1:0] left;
		logic do_trail;
		logic tmr_on;
		logic [17:0] ms_div;
		logic [STP_TW-1:0] ms_cnt;
		logic rx_ready;
		logic tx_valid;
		logic [7:0] tx_data;
		logic tx_last;
		logic dtr;
	} stp_state_s;

	stp_state_s q;
	stp_state_s next_q;
	logic conn;
	logic push;
	logic fire;
	logic tx_take;
	logic [STP_CW-1:0] cap;

	// ****************************************
	// packing and dtr
	// ****************************************
	always_comb
	begin
		next_q = q;
		conn = accept_active | connect_active;
		cap = (buf_size == '0 || buf_size > 5'(STP_DEPTH)) ? 5'(STP_DEPTH) : buf_size;
		push = rx_valid && q.rx_ready;
		tx_take = q.tx_valid && tx_ready;
		fire = 1'b0;
		case (dtr_policy)
			STP_DTR_NEVER: next_q.dtr = 1'b0;
			STP_DTR_REMOTE_DSR_FOLLOW: next_q.dtr = conn & remote_dsr;
			STP_DTR_CONNECTED: next_q.dtr = conn;
			STP_DTR_ALWAYS: next_q.dtr = 1'b1;
			default: next_q.dtr = 1'b0;
		endcase
		if (push)
		begin
			next_q.mem[q.wr] = rx_data;
			next_q.wr = q.wr + 1'b1;
			next_q.cnt = q.cnt + 1'b1;
		end
		if (q.tmr_on)
		begin
			if (q.ms_div == STP_MS_LAST)
			begin
				next_q.ms_div = '0;
				next_q.ms_cnt = q.ms_cnt + 1'b1;
			end
			else
				next_q.ms_div = q.ms_div + 1'b1;
		end
		else if (push && pack_mode == STP_PACK_TIMEOUT)
		begin
			next_q.tmr_on = 1'b1;
			next_q.ms_div = '0;
			next_q.ms_cnt = '0;
		end
		case (q.st)
			STP_FILL:
			begin
				next_q.tx_valid = 1'b0;
				if (pack_mode == STP_PACK_DISABLE)
					fire = conn && q.cnt != '0;
				else if (conn)
				begin
					// a threshold of zero leaves the byte-count trigger off
					if (threshold != '0 && next_q.cnt >= threshold) fire = 1'b1;
					if (pack_mode == STP_PACK_TIMEOUT && q.tmr_on && q.ms_cnt >= timeout_ms)
						fire = 1'b1;
					if (pack_mode == STP_PACK_SENDCHAR && push && rx_data == send_char)
					begin
						fire = 1'b1;
						next_q.do_trail = trail_en;
					end
				end
				if (fire)
				begin
					next_q.st = STP_SEND;
					next_q.left = next_q.cnt;
					next_q.cnt = '0;
					next_q.tmr_on = 1'b0;
				end
				next_q.rx_ready = !fire && next_q.cnt < cap;
			end
			STP_SEND:
			begin
				next_q.rx_ready = 1'b0;
				if (!q.tx_valid || tx_take)
				begin
					if (q.left == '0)
					begin
						next_q.tx_valid = 1'b0;
						next_q.st = q.do_trail ? STP_TRAIL : STP_FILL;
						next_q.rx_ready = !q.do_trail;
					end
					else
					begin
						next_q.tx_valid = 1'b1;
						next_q.tx_data = q.mem[q.rd];
						next_q.tx_last = q.left == 5'd1 && !q.do_trail;
						next_q.rd = q.rd + 1'b1;
						next_q.left = q.left - 1'b1;
					end
				end
			end
			STP_TRAIL:
			begin
				if (!q.tx_valid)
				begin
					next_q.tx_valid = 1'b1;
					next_q.tx_data = trail_char;
					next_q.tx_last = 1'b1;
				end
				else if (tx_take)
				begin
					next_q.tx_valid = 1'b0;
					next_q.do_trail = 1'b0;
					next_q.st = STP_FILL;
					next_q.rx_ready = 1'b1;
				end
			end
			default: next_q.st = STP_FILL;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.st <= STP_FILL;
			q.tx_data <= STP_BYTE_RST;
		end
		else
			q <= next_q;
	end

	assign rx_ready = q.rx_ready;
	assign tx_valid = q.tx_valid;
	assign tx_data = q.tx_data;
	assign tx_last = q.tx_last;
	assign dtr = q.dtr;
	assign queued = q.cnt;

	// ****************************************
	// checks
	// ****************************************
	dtr_never_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(dtr_policy) == STP_DTR_NEVER |-> !dtr) else $error("dtr asserted in never policy");
	dtr_dsr_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(dtr_policy) == STP_DTR_REMOTE_DSR_FOLLOW |-> dtr == $past(conn & remote_dsr))
		else $error("dtr not following remote dsr");
	dtr_conn_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(dtr_policy) == STP_DTR_CONNECTED |-> dtr == $past(conn)) else $error("dtr not connection");
	dtr_always_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(dtr_policy) == STP_DTR_ALWAYS |-> dtr) else $error("dtr low in continuous policy");
	buf_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		queued <= cap) else $error("queue beyond capacity");
	thresh_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
		q.st == STP_FILL && pack_mode != STP_PACK_DISABLE && conn && push && threshold != '0
		&& q.cnt + 5'd1 >= threshold |=> q.st == STP_SEND && queued == '0)
		else $error("threshold did not send");
	char_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
		q.st == STP_FILL && pack_mode == STP_PACK_SENDCHAR && conn && push && rx_data == send_char
		|=> q.st == STP_SEND && !q.tmr_on) else $error("send char did not send");
	no_timer_a: assert property (@(posedge mclk) disable iff (!rst_n)
		pack_mode != STP_PACK_TIMEOUT && !q.tmr_on |=> !q.tmr_on) else $error("timer outside timeout mode");
	trail_a: assert property (@(posedge mclk) disable iff (!rst_n)
		q.st == STP_TRAIL && tx_valid |-> tx_data == trail_char && tx_last) else $error("bad trailing byte");
	tmo_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
		q.st == STP_FILL && pack_mode == STP_PACK_TIMEOUT && conn && q.tmr_on && q.ms_cnt >= timeout_ms
		|=> q.st == STP_SEND && !q.tmr_on) else $error("timeout did not send");
	pack_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
		q.st == STP_FILL && pack_mode == STP_PACK_DISABLE && !conn |=> q.st == STP_FILL)
		else $error("disabled packing sent without connection");
	pkt_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		q.st == STP_FILL ##1 q.st == STP_SEND |-> queued == '0 && !q.tmr_on && !rx_ready)
		else $error("count or timer left after packet");
	tx_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("packet byte dropped");
	send_cov: cover property (@(posedge mclk) disable iff (!rst_n) q.st == STP_SEND ##1 q.st == STP_TRAIL);
	tmo_cov: cover property (@(posedge mclk) disable iff (!rst_n) q.tmr_on ##1 !q.tmr_on);
	full_cov: cover property (@(posedge mclk) disable iff (!rst_n) queued == cap && !rx_ready);
	dis_cov: cover property (@(posedge mclk) disable iff (!rst_n) q.st == STP_FILL && pack_mode == STP_PACK_DISABLE && fire);
endmodule

// >>> dv/stp_net_sink.sv
`timescale 1ns/10ps
module stp_net_sink
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	logic [7:0] got[$];
	logic lst[$];
	// network side stalls about one cycle in four
	initial
	begin
		tx_ready = 1'b0;
		forever
		begin
			@(negedge mclk);
			tx_ready = rst_n && ($urandom % 4 != 0);
		end
	end
	always @(posedge mclk)
		if (tx_valid && tx_ready)
		begin
			got.push_back(tx_data);
			lst.push_back(tx_last);
		end
endmodule

// >>> dv/stp_packer_tb.sv
`timescale 1ns/10ps
module stp_packer_tb;
	import stp_pkg::*;
	logic mclk = 0, rst_n = 0, trail_en = 0, acc = 0, con = 0, rdsr = 0, rx_valid = 0;
	logic rx_ready, tx_valid, tx_ready, dtr, txl;
	stp_dtr_e pol = STP_DTR_NEVER;
	stp_pack_e mode = STP_PACK_DISABLE;
	logic [4:0] bsz = 5'h00, thr = 5'h00, queued;
	logic [15:0] tms = 16'hffff;
	logic [7:0] sc = 8'h0d, tc = 8'h0a, rxd = 8'h00, txd, b;
	logic [7:0] exp[$];
	int bad_count = 0, n_tests = 0;
	stp_packer stp_packer_inst (.mclk(mclk), .rst_n(rst_n), .dtr_policy(pol), .pack_mode(mode),
		.buf_size(bsz), .threshold(thr), .timeout_ms(tms), .send_char(sc), .trail_en(trail_en),
		.trail_char(tc), .accept_active(acc), .connect_active(con), .remote_dsr(rdsr),
		.rx_valid(rx_valid), .rx_data(rxd), .tx_ready(tx_ready), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(txd), .tx_last(txl), .dtr(dtr), .queued(queued));
	stp_net_sink stp_net_sink_inst (.mclk(mclk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_data(txd),
		.tx_last(txl), .tx_ready(tx_ready));
	initial forever #2.5 mclk = ~mclk;
	// ****************
	// checking helpers
	// ****************
	task automatic chk(string what, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic put(logic [7:0] v);
		int i;
		@(negedge mclk);
		rx_valid = 1;
		rxd = v;
		for (i = 0; i < 500 && rx_ready !== 1'b1; i++)
			@(negedge mclk);
		if (i == 500)
		begin
			bad_count++;
			$display("MISMATCH rx_ready expected 1 seen %b", rx_ready);
		end
		@(posedge mclk);
	endtask
	// waits for the expected packet, then checks nothing extra follows
	task automatic pkt(string what);
		int i;
		@(negedge mclk);
		rx_valid = 0;
		for (i = 0; i < 500 && stp_net_sink_inst.got.size() < exp.size(); i++)
			@(posedge mclk);
		repeat (8) @(negedge mclk);
		chk({what, " len"}, 8'(exp.size()), 8'(stp_net_sink_inst.got.size()));
		foreach (exp[k])
		begin
			chk(what, exp[k], stp_net_sink_inst.got[k]);
			chk({what, " last"}, {7'h00, k == exp.size() - 1}, {7'h00, stp_net_sink_inst.lst[k]});
		end
		chk("queued", 8'h00, {3'h0, queued});
		stp_net_sink_inst.got = {};
		stp_net_sink_inst.lst = {};
		exp = {};
		$display("test %s done", what);
	endtask
	function automatic logic exp_dtr();
		case (pol)
			STP_DTR_NEVER: return 1'b0;
			STP_DTR_REMOTE_DSR_FOLLOW: return (acc | con) & rdsr;
			STP_DTR_CONNECTED: return acc | con;
			default: return 1'b1;
		endcase
	endfunction
	initial
	begin
		void'($urandom(32'hfe59));
		repeat (8) @(negedge mclk);
		rst_n = 1;
		repeat (2) @(negedge mclk);
		repeat (40)
		begin
			pol = stp_dtr_e'(2'($urandom));
			{acc, con, rdsr} = 3'($urandom);
			repeat (2) @(negedge mclk);
			chk("dtr", {7'h00, exp_dtr()}, {7'h00, dtr});
		end
		$display("test dtr done");
		{acc, con, bsz} = {2'b00, 5'h02};
		put(sc);
		put(8'h41);
		@(negedge mclk);
		rx_valid = 0;
		repeat (3) @(negedge mclk);
		chk("held", 8'h02, {3'h0, queued});
		chk("full", 8'h00, {7'h00, rx_ready | tx_valid});
		con = 1;
		exp = {sc, 8'h41};
		pkt("disabled");
		bsz = 5'h00;
		mode = STP_PACK_SENDCHAR;
		repeat (4)
		begin
			sc = 8'($urandom);
			trail_en = 1'($urandom);
			repeat ($urandom % 6)
			begin
				b = 8'($urandom);
				b = (b == sc) ? ~b : b;
				exp.push_back(b);
				put(b);
			end
			exp.push_back(sc);
			if (trail_en)
				exp.push_back(tc);
			put(sc);
			pkt("sendchar");
		end
		sc = 8'h0d;
		trail_en = 1'b0;
		for (int m = 1; m < 3; m++)
		begin
			mode = stp_pack_e'(m);
			thr = 5'h03;
			exp = {~sc, 8'h00, 8'h7f};
			foreach (exp[k])
				put(exp[k]);
			pkt("threshold");
		end
		thr = 5'h00;
		tms = 16'h0000;
		put(8'h5a);
		@(negedge mclk);
		rx_valid = 0;
		repeat (20) @(negedge mclk);
		chk("no timeout len", 8'h00, 8'(stp_net_sink_inst.got.size()));
		chk("no timeout queued", 8'h01, {3'h0, queued});
		$display("test sendchar no timeout done");
		mode = STP_PACK_TIMEOUT;
		put(8'h33);
		exp = {8'h5a, 8'h33};
		pkt("timeout");
		give_verdict();
	end
endmodule
